// ===== hdl/gio_pkg.sv
package gio_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned GIO_ADDR_W = 8;
  localparam int unsigned GIO_DATA_W = 32;
  localparam int unsigned GIO_LOW_W  = 24;
  localparam int unsigned GIO_HIGH_W = 8;
  localparam int unsigned GIO_MUX_W  = 16;
  localparam int unsigned GIO_DISP_W = 8;
  localparam int unsigned GIO_NPTS   = 56;
  localparam int unsigned GIO_NBUF   = 7;
  localparam int unsigned GIO_BYTE_W = 8;

  // ==========================================================================
  // Point positions in the pad vector
  // ==========================================================================
  localparam int unsigned GIO_POS_LOW  = 0;
  localparam int unsigned GIO_POS_HIGH = 24;
  localparam int unsigned GIO_POS_MUX  = 32;
  localparam int unsigned GIO_POS_DISP = 48;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] GIO_OFS_LOW_MODE   = 8'h00;
  localparam logic [7:0] GIO_OFS_HIGH_MODE  = 8'h04;
  localparam logic [7:0] GIO_OFS_MUX_MODE   = 8'h08;
  localparam logic [7:0] GIO_OFS_DISP_MODE  = 8'h0C;
  localparam logic [7:0] GIO_OFS_ID_CTRL0   = 8'h10;
  localparam logic [7:0] GIO_OFS_ID_VAL0    = 8'h14;
  localparam logic [7:0] GIO_OFS_ID_VAL1    = 8'h18;
  localparam logic [7:0] GIO_OFS_LOW_DIR    = 8'h1C;
  localparam logic [7:0] GIO_OFS_HIGH_DIR   = 8'h20;
  localparam logic [7:0] GIO_OFS_MUX_DIR    = 8'h24;
  localparam logic [7:0] GIO_OFS_DISP_DIR   = 8'h28;
  localparam logic [7:0] GIO_OFS_LOW_POL    = 8'h2C;
  localparam logic [7:0] GIO_OFS_HIGH_POL   = 8'h30;
  localparam logic [7:0] GIO_OFS_MUX_POL    = 8'h34;
  localparam logic [7:0] GIO_OFS_DISP_POL   = 8'h38;
  localparam logic [7:0] GIO_OFS_LOW_DATA   = 8'h3C;
  localparam logic [7:0] GIO_OFS_HIGH_DATA  = 8'h40;
  localparam logic [7:0] GIO_OFS_MUX_DATA   = 8'h44;
  localparam logic [7:0] GIO_OFS_DISP_DATA  = 8'h48;
  localparam logic [7:0] GIO_OFS_LOW_INP    = 8'h4C;
  localparam logic [7:0] GIO_OFS_HIGH_INP   = 8'h50;
  localparam logic [7:0] GIO_OFS_MUX_INP    = 8'h54;
  localparam logic [7:0] GIO_OFS_DISP_INP   = 8'h58;

  // ==========================================================================
  // Buffer direction bit positions
  // ==========================================================================
  localparam int unsigned GIO_IDC_BUF_BIT  = 7;
  localparam int unsigned GIO_IDV0_B1_BIT  = 0;
  localparam int unsigned GIO_IDV0_B2_BIT  = 1;
  localparam int unsigned GIO_IDV0_B3_BIT  = 2;
  localparam int unsigned GIO_IDV0_RD_BIT  = 3;
  localparam int unsigned GIO_IDV1_ADR_BIT = 0;
  localparam int unsigned GIO_IDV1_IND_BIT = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [23:0] GIO_RST_LOW_MODE  = 24'hFFFFFF;
  localparam logic [7:0]  GIO_RST_HIGH_MODE = 8'hFF;
  localparam logic [15:0] GIO_RST_MUX_MODE  = 16'hFFFF;
  localparam logic [7:0]  GIO_RST_DISP_MODE = 8'hFF;
  localparam logic [7:0]  GIO_RST_BYTE      = 8'h00;
  localparam logic [23:0] GIO_RST_LOW       = 24'h000000;
  localparam logic [15:0] GIO_RST_MUX       = 16'h0000;
  localparam logic [31:0] GIO_RST_WORD      = 32'h00000000;
  localparam logic [55:0] GIO_RST_PADS      = 56'h00000000000000;

endpackage

// ===== hdl/gio_sync.sv
`timescale 1ns/100ps
module gio_sync
  import gio_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
  } gio_sync_state_type;

  gio_sync_state_type st_r;
  gio_sync_state_type st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta_r = d_i;
    st_nxt.sync_r = st_r.meta_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.sync_r;

endmodule // gio_sync

// ===== hdl/gio_pin_group.sv
`timescale 1ns/100ps
module gio_pin_group
  import gio_pkg::*;
#(
  parameter int unsigned W         = 8,
  parameter bit          FORCE_OUT = 1'b0
) (
  input  wire logic [W-1:0] mode_i,
  input  wire logic [W-1:0] dir_i,
  input  wire logic [W-1:0] pol_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] servo_out_i,
  input  wire logic [W-1:0] servo_oe_i,
  output logic      [W-1:0] pad_out_o,
  output logic      [W-1:0] pad_oe_o,
  output logic      [W-1:0] value_o
);

  // ==========================================================================
  // Per-point steering
  // ==========================================================================
  always_comb begin
    for (int i = 0; i < W; i++) begin
      value_o[i] = pin_i[i] ^ pol_i[i];
      if (FORCE_OUT) begin
        pad_oe_o[i]  = 1'b1;
        pad_out_o[i] = data_i[i] ^ pol_i[i];
      end else if (mode_i[i]) begin
        pad_oe_o[i]  = dir_i[i];
        pad_out_o[i] = data_i[i] ^ pol_i[i];
      end else begin
        pad_oe_o[i]  = servo_oe_i[i];
        pad_out_o[i] = servo_out_i[i];
      end
    end
  end

endmodule // gio_pin_group

// ===== hdl/gio_port.sv
// Function
// - Each pin whose mode bit is one is general-purpose, a zero gives it to the servo function.
// - Points 24 to 31 and the indicator lines are always general-purpose outputs.
// - A buffer direction bit of 0 makes its byte buffer an input, 1 an output.
// - Control bit 7 steers points 0-7, first value bits 0-3 steer the next three bytes and the read lines, second value bits 0-1 the address and indicator lines.
// - A direction bit of 0 makes the point an input, 1 an output.
// - Inversion is chosen per point and acts on input and output alike. Here a servo-mode point drives servo_out_i to its pad uninverted.
// - Polarity 0 makes logical 1 a high pin, polarity 1 makes it a low pin.
// - In the first buffer control register only bit 7 is writable.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module gio_port
  import gio_pkg::*;
#(
  parameter logic [6:0] ID_CTRL_LOW = 7'h00 // Arbitrary read-only value
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [GIO_ADDR_W-1:0] addr_i,
  input  wire logic [GIO_DATA_W-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [GIO_DATA_W-1:0] rdata_o,
  input  wire logic [GIO_NPTS-1:0]   pad_in_i,
  output logic      [GIO_NPTS-1:0]   pad_out_o,
  output logic      [GIO_NPTS-1:0]   pad_oe_o,
  output logic      [GIO_NBUF-1:0]   buf_dir_o,
  input  wire logic [GIO_NPTS-1:0]   servo_out_i,
  input  wire logic [GIO_NPTS-1:0]   servo_oe_i,
  output logic      [GIO_NPTS-1:0]   servo_in_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [GIO_LOW_W-1:0]  low_mode_r;
    logic [GIO_HIGH_W-1:0] high_mode_r;
    logic [GIO_MUX_W-1:0]  mux_mode_r;
    logic [GIO_DISP_W-1:0] disp_mode_r;
    logic                  id_ctrl_bit_r;
    logic [GIO_BYTE_W-1:0] id_val0_r;
    logic [GIO_BYTE_W-1:0] id_val1_r;
    logic [GIO_LOW_W-1:0]  low_dir_r;
    logic [GIO_HIGH_W-1:0] high_dir_r;
    logic [GIO_MUX_W-1:0]  mux_dir_r;
    logic [GIO_DISP_W-1:0] disp_dir_r;
    logic [GIO_LOW_W-1:0]  low_pol_r;
    logic [GIO_HIGH_W-1:0] high_pol_r;
    logic [GIO_MUX_W-1:0]  mux_pol_r;
    logic [GIO_DISP_W-1:0] disp_pol_r;
    logic [GIO_LOW_W-1:0]  low_data_r;
    logic [GIO_HIGH_W-1:0] high_data_r;
    logic [GIO_MUX_W-1:0]  mux_data_r;
    logic [GIO_DISP_W-1:0] disp_data_r;
    logic [GIO_NPTS-1:0]   pad_out_r;
    logic [GIO_NPTS-1:0]   pad_oe_r;
    logic [GIO_DATA_W-1:0] rdata_r;
  } gio_state_type;

  gio_state_type st_r;
  gio_state_type st_nxt;

  logic [GIO_NPTS-1:0] pin_sync;
  logic [GIO_NPTS-1:0] grp_out;
  logic [GIO_NPTS-1:0] grp_oe;
  logic [GIO_NPTS-1:0] grp_val;

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  gio_sync #(
    .W (GIO_NPTS)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (pad_in_i),
    .q_o       (pin_sync)
  );

  // ==========================================================================
  // Point groups
  // ==========================================================================
  gio_pin_group #(
    .W         (GIO_LOW_W),
    .FORCE_OUT (1'b0)
  ) u_low (
    .mode_i      (st_r.low_mode_r),
    .dir_i       (st_r.low_dir_r),
    .pol_i       (st_r.low_pol_r),
    .data_i      (st_r.low_data_r),
    .pin_i       (pin_sync[GIO_POS_LOW +: GIO_LOW_W]),
    .servo_out_i (servo_out_i[GIO_POS_LOW +: GIO_LOW_W]),
    .servo_oe_i  (servo_oe_i[GIO_POS_LOW +: GIO_LOW_W]),
    .pad_out_o   (grp_out[GIO_POS_LOW +: GIO_LOW_W]),
    .pad_oe_o    (grp_oe[GIO_POS_LOW +: GIO_LOW_W]),
    .value_o     (grp_val[GIO_POS_LOW +: GIO_LOW_W])
  );

  gio_pin_group #(
    .W         (GIO_HIGH_W),
    .FORCE_OUT (1'b1)
  ) u_high (
    .mode_i      (st_r.high_mode_r),
    .dir_i       (st_r.high_dir_r),
    .pol_i       (st_r.high_pol_r),
    .data_i      (st_r.high_data_r),
    .pin_i       (pin_sync[GIO_POS_HIGH +: GIO_HIGH_W]),
    .servo_out_i (servo_out_i[GIO_POS_HIGH +: GIO_HIGH_W]),
    .servo_oe_i  (servo_oe_i[GIO_POS_HIGH +: GIO_HIGH_W]),
    .pad_out_o   (grp_out[GIO_POS_HIGH +: GIO_HIGH_W]),
    .pad_oe_o    (grp_oe[GIO_POS_HIGH +: GIO_HIGH_W]),
    .value_o     (grp_val[GIO_POS_HIGH +: GIO_HIGH_W])
  );

  gio_pin_group #(
    .W         (GIO_MUX_W),
    .FORCE_OUT (1'b0)
  ) u_mux (
    .mode_i      (st_r.mux_mode_r),
    .dir_i       (st_r.mux_dir_r),
    .pol_i       (st_r.mux_pol_r),
    .data_i      (st_r.mux_data_r),
    .pin_i       (pin_sync[GIO_POS_MUX +: GIO_MUX_W]),
    .servo_out_i (servo_out_i[GIO_POS_MUX +: GIO_MUX_W]),
    .servo_oe_i  (servo_oe_i[GIO_POS_MUX +: GIO_MUX_W]),
    .pad_out_o   (grp_out[GIO_POS_MUX +: GIO_MUX_W]),
    .pad_oe_o    (grp_oe[GIO_POS_MUX +: GIO_MUX_W]),
    .value_o     (grp_val[GIO_POS_MUX +: GIO_MUX_W])
  );

  gio_pin_group #(
    .W         (GIO_DISP_W),
    .FORCE_OUT (1'b1)
  ) u_disp (
    .mode_i      (st_r.disp_mode_r),
    .dir_i       (st_r.disp_dir_r),
    .pol_i       (st_r.disp_pol_r),
    .data_i      (st_r.disp_data_r),
    .pin_i       (pin_sync[GIO_POS_DISP +: GIO_DISP_W]),
    .servo_out_i (servo_out_i[GIO_POS_DISP +: GIO_DISP_W]),
    .servo_oe_i  (servo_oe_i[GIO_POS_DISP +: GIO_DISP_W]),
    .pad_out_o   (grp_out[GIO_POS_DISP +: GIO_DISP_W]),
    .pad_oe_o    (grp_oe[GIO_POS_DISP +: GIO_DISP_W]),
    .value_o     (grp_val[GIO_POS_DISP +: GIO_DISP_W])
  );

  // ==========================================================================
  // Next state: register writes, read capture, pad registers
  // ==========================================================================
  always_comb begin
    st_nxt           = st_r;
    st_nxt.pad_out_r = grp_out;
    st_nxt.pad_oe_r  = grp_oe;
    if (wr_i) begin
      case (addr_i)
        GIO_OFS_LOW_MODE:  st_nxt.low_mode_r  = wdata_i[GIO_LOW_W-1:0];
        GIO_OFS_HIGH_MODE: st_nxt.high_mode_r = wdata_i[GIO_HIGH_W-1:0];
        GIO_OFS_MUX_MODE:  st_nxt.mux_mode_r  = wdata_i[GIO_MUX_W-1:0];
        GIO_OFS_DISP_MODE: st_nxt.disp_mode_r = wdata_i[GIO_DISP_W-1:0];
        GIO_OFS_ID_CTRL0:  st_nxt.id_ctrl_bit_r = wdata_i[GIO_IDC_BUF_BIT];
        GIO_OFS_ID_VAL0:   st_nxt.id_val0_r   = wdata_i[GIO_BYTE_W-1:0];
        GIO_OFS_ID_VAL1:   st_nxt.id_val1_r   = wdata_i[GIO_BYTE_W-1:0];
        GIO_OFS_LOW_DIR:   st_nxt.low_dir_r   = wdata_i[GIO_LOW_W-1:0];
        GIO_OFS_HIGH_DIR:  st_nxt.high_dir_r  = wdata_i[GIO_HIGH_W-1:0];
        GIO_OFS_MUX_DIR:   st_nxt.mux_dir_r   = wdata_i[GIO_MUX_W-1:0];
        GIO_OFS_DISP_DIR:  st_nxt.disp_dir_r  = wdata_i[GIO_DISP_W-1:0];
        GIO_OFS_LOW_POL:   st_nxt.low_pol_r   = wdata_i[GIO_LOW_W-1:0];
        GIO_OFS_HIGH_POL:  st_nxt.high_pol_r  = wdata_i[GIO_HIGH_W-1:0];
        GIO_OFS_MUX_POL:   st_nxt.mux_pol_r   = wdata_i[GIO_MUX_W-1:0];
        GIO_OFS_DISP_POL:  st_nxt.disp_pol_r  = wdata_i[GIO_DISP_W-1:0];
        GIO_OFS_LOW_DATA:  st_nxt.low_data_r  = wdata_i[GIO_LOW_W-1:0];
        GIO_OFS_HIGH_DATA: st_nxt.high_data_r = wdata_i[GIO_HIGH_W-1:0];
        GIO_OFS_MUX_DATA:  st_nxt.mux_data_r  = wdata_i[GIO_MUX_W-1:0];
        GIO_OFS_DISP_DATA: st_nxt.disp_data_r = wdata_i[GIO_DISP_W-1:0];
        default: begin
        end
      endcase
    end
    st_nxt.rdata_r = GIO_RST_WORD;
    if (rd_i) begin
      case (addr_i)
        GIO_OFS_LOW_MODE:  st_nxt.rdata_r = 32'(st_r.low_mode_r);
        GIO_OFS_HIGH_MODE: st_nxt.rdata_r = 32'(st_r.high_mode_r);
        GIO_OFS_MUX_MODE:  st_nxt.rdata_r = 32'(st_r.mux_mode_r);
        GIO_OFS_DISP_MODE: st_nxt.rdata_r = 32'(st_r.disp_mode_r);
        GIO_OFS_ID_CTRL0:  st_nxt.rdata_r =
                             32'({st_r.id_ctrl_bit_r, ID_CTRL_LOW});
        GIO_OFS_ID_VAL0:   st_nxt.rdata_r = 32'(st_r.id_val0_r);
        GIO_OFS_ID_VAL1:   st_nxt.rdata_r = 32'(st_r.id_val1_r);
        GIO_OFS_LOW_DIR:   st_nxt.rdata_r = 32'(st_r.low_dir_r);
        GIO_OFS_HIGH_DIR:  st_nxt.rdata_r = 32'(st_r.high_dir_r);
        GIO_OFS_MUX_DIR:   st_nxt.rdata_r = 32'(st_r.mux_dir_r);
        GIO_OFS_DISP_DIR:  st_nxt.rdata_r = 32'(st_r.disp_dir_r);
        GIO_OFS_LOW_POL:   st_nxt.rdata_r = 32'(st_r.low_pol_r);
        GIO_OFS_HIGH_POL:  st_nxt.rdata_r = 32'(st_r.high_pol_r);
        GIO_OFS_MUX_POL:   st_nxt.rdata_r = 32'(st_r.mux_pol_r);
        GIO_OFS_DISP_POL:  st_nxt.rdata_r = 32'(st_r.disp_pol_r);
        GIO_OFS_LOW_DATA:  st_nxt.rdata_r = 32'(st_r.low_data_r);
        GIO_OFS_HIGH_DATA: st_nxt.rdata_r = 32'(st_r.high_data_r);
        GIO_OFS_MUX_DATA:  st_nxt.rdata_r = 32'(st_r.mux_data_r);
        GIO_OFS_DISP_DATA: st_nxt.rdata_r = 32'(st_r.disp_data_r);
        GIO_OFS_LOW_INP:   st_nxt.rdata_r =
                             32'(grp_val[GIO_POS_LOW +: GIO_LOW_W]);
        GIO_OFS_HIGH_INP:  st_nxt.rdata_r =
                             32'(grp_val[GIO_POS_HIGH +: GIO_HIGH_W]);
        GIO_OFS_MUX_INP:   st_nxt.rdata_r =
                             32'(grp_val[GIO_POS_MUX +: GIO_MUX_W]);
        GIO_OFS_DISP_INP:  st_nxt.rdata_r =
                             32'(grp_val[GIO_POS_DISP +: GIO_DISP_W]);
        default:           st_nxt.rdata_r = GIO_RST_WORD;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.low_mode_r    <= GIO_RST_LOW_MODE;
      st_r.high_mode_r   <= GIO_RST_HIGH_MODE;
      st_r.mux_mode_r    <= GIO_RST_MUX_MODE;
      st_r.disp_mode_r   <= GIO_RST_DISP_MODE;
      st_r.id_ctrl_bit_r <= 1'b0;
      st_r.id_val0_r     <= GIO_RST_BYTE;
      st_r.id_val1_r     <= GIO_RST_BYTE;
      st_r.low_dir_r     <= GIO_RST_LOW;
      st_r.high_dir_r    <= GIO_RST_BYTE;
      st_r.mux_dir_r     <= GIO_RST_MUX;
      st_r.disp_dir_r    <= GIO_RST_BYTE;
      st_r.low_pol_r     <= GIO_RST_LOW;
      st_r.high_pol_r    <= GIO_RST_BYTE;
      st_r.mux_pol_r     <= GIO_RST_MUX;
      st_r.disp_pol_r    <= GIO_RST_BYTE;
      st_r.low_data_r    <= GIO_RST_LOW;
      st_r.high_data_r   <= GIO_RST_BYTE;
      st_r.mux_data_r    <= GIO_RST_MUX;
      st_r.disp_data_r   <= GIO_RST_BYTE;
      st_r.pad_out_r     <= GIO_RST_PADS;
      st_r.pad_oe_r      <= GIO_RST_PADS;
      st_r.rdata_r       <= GIO_RST_WORD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rdata_o    = st_r.rdata_r;
  assign pad_out_o  = st_r.pad_out_r;
  assign pad_oe_o   = st_r.pad_oe_r;
  assign servo_in_o = pin_sync;

  // Byte buffer directions, 1 drives outward
  assign buf_dir_o = {st_r.id_val1_r[GIO_IDV1_IND_BIT],
                      st_r.id_val1_r[GIO_IDV1_ADR_BIT],
                      st_r.id_val0_r[GIO_IDV0_RD_BIT],
                      st_r.id_val0_r[GIO_IDV0_B3_BIT],
                      st_r.id_val0_r[GIO_IDV0_B2_BIT],
                      st_r.id_val0_r[GIO_IDV0_B1_BIT],
                      st_r.id_ctrl_bit_r};

endmodule // gio_port

// ===== testbench/gio_port_checker.sv
`timescale 1ns/100ps
module gio_port_checker
  import gio_pkg::*;
#(
  parameter logic [6:0] ID_CTRL_LOW = 7'h00
) (
  input wire logic                  ref_clk_i,
  input wire logic                  rst_n_i,
  input wire logic [GIO_ADDR_W-1:0] addr_i,
  input wire logic [GIO_DATA_W-1:0] wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [GIO_DATA_W-1:0] rdata_o,
  input wire logic [GIO_NPTS-1:0]   pad_in_i,
  input wire logic [GIO_NPTS-1:0]   pad_out_o,
  input wire logic [GIO_NPTS-1:0]   pad_oe_o,
  input wire logic [GIO_NBUF-1:0]   buf_dir_o,
  input wire logic [GIO_NPTS-1:0]   servo_out_i,
  input wire logic [GIO_NPTS-1:0]   servo_oe_i
);
  // =====
  // Shadow of the low group, the high group data and polarity, and buffer bits
  logic [23:0] lm_r, ld_r, lp_r, lq_r, p1_r, p2_r, oe_x, out_x, inp_x;
  logic [7:0]  hq_r, hp_r, hv_x, cr_x;
  logic [6:0]  bm_r;
  assign oe_x  = (lm_r & ld_r) | (~lm_r & servo_oe_i[23:0]);
  assign out_x = (lm_r & (lq_r ^ lp_r)) | (~lm_r & servo_out_i[23:0]);
  assign inp_x = p2_r ^ lp_r;
  assign hv_x  = hq_r ^ hp_r;
  assign cr_x  = {bm_r[0], ID_CTRL_LOW};
  always_ff @(posedge ref_clk_i) begin
    p1_r <= pad_in_i[23:0];
    p2_r <= p1_r;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lm_r <= GIO_RST_LOW_MODE;
      ld_r <= GIO_RST_LOW;
      lp_r <= GIO_RST_LOW;
      lq_r <= GIO_RST_LOW;
      hq_r <= GIO_RST_BYTE;
      hp_r <= GIO_RST_BYTE;
      bm_r <= 7'h00;
    end else if (wr_i) begin
      case (addr_i)
        GIO_OFS_LOW_MODE:  lm_r <= wdata_i[23:0];
        GIO_OFS_LOW_DIR:   ld_r <= wdata_i[23:0];
        GIO_OFS_LOW_POL:   lp_r <= wdata_i[23:0];
        GIO_OFS_LOW_DATA:  lq_r <= wdata_i[23:0];
        GIO_OFS_HIGH_POL:  hp_r <= wdata_i[7:0];
        GIO_OFS_HIGH_DATA: hq_r <= wdata_i[7:0];
        GIO_OFS_ID_CTRL0:  bm_r[0] <= wdata_i[7];
        GIO_OFS_ID_VAL0:   bm_r[4:1] <= wdata_i[3:0];
        GIO_OFS_ID_VAL1:   bm_r[6:5] <= wdata_i[1:0];
        default: ;
      endcase
    end
  end
  // =====
  // Properties
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_fixed_out_en: assert property (
    $past(rst_n_i) |-> (&pad_oe_o[31:24]) && (&pad_oe_o[55:48]))
    else $error("fixed output points not enabled");
  a_low_oe_map: assert property (
    $past(rst_n_i) |-> pad_oe_o[23:0] == $past(oe_x))
    else $error("low point enable wrong");
  a_low_out_map: assert property (
    $past(rst_n_i) |-> pad_out_o[23:0] == $past(out_x))
    else $error("low point drive level wrong");
  a_high_out_val: assert property (
    $past(rst_n_i) |-> pad_out_o[31:24] == $past(hv_x))
    else $error("high point drive level wrong");
  a_buf_dir_map: assert property (
    bm_r == $past(bm_r) |-> buf_dir_o == bm_r)
    else $error("buffer direction wrong");
  a_dir_readback: assert property (
    rd_i && addr_i == GIO_OFS_LOW_DIR |=> rdata_o == {8'h00, $past(ld_r)})
    else $error("low direction readback wrong");
  a_ctrl_read_only: assert property (
    rd_i && addr_i == GIO_OFS_ID_CTRL0 |=> rdata_o == {24'h0, $past(cr_x)})
    else $error("buffer control readback wrong");
  a_input_pol: assert property (
    rd_i && addr_i == GIO_OFS_LOW_INP && $past(rst_n_i, 3) && p1_r == p2_r
    && pad_in_i[23:0] == p1_r |=> rdata_o == {8'h00, $past(inp_x)})
    else $error("low input value wrong");
  c_servo_pin: cover property (|(~lm_r));
  c_inp_read: cover property (rd_i && addr_i == GIO_OFS_LOW_INP);
  c_buf_out: cover property (|buf_dir_o);
endmodule // gio_port_checker

bind gio_port gio_port_checker #(.ID_CTRL_LOW(ID_CTRL_LOW)) u_chk (
  .ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .pad_in_i, .pad_out_o, .pad_oe_o, .buf_dir_o, .servo_out_i, .servo_oe_i
);

// ===== testbench/gio_line_model.sv
`timescale 1ns/100ps
module gio_line_model
  import gio_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic [GIO_NPTS-1:0] pad_out_i,
  input  wire logic [GIO_NPTS-1:0] pad_oe_i,
  input  wire logic [GIO_NBUF-1:0] buf_dir_i,
  input  wire logic [GIO_NPTS-1:0] ext_i,
  output logic      [GIO_NPTS-1:0] pad_in_o
);
  logic flt_r = 1'b0;
  always @(posedge ref_clk_i) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < GIO_NPTS; i++) begin
      if (!buf_dir_i[i / GIO_BYTE_W])
        pad_in_o[i] = ext_i[i];
      else if (pad_oe_i[i])
        pad_in_o[i] = pad_out_i[i];
      else // Released line toggles
        pad_in_o[i] = flt_r ^ i[0];
    end
  end
endmodule // gio_line_model

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import gio_pkg::*;
  logic                  ref_clk_i   = 1'b0;
  logic                  rst_n_i     = 1'b0;
  logic [GIO_ADDR_W-1:0] addr_i      = '0;
  logic [GIO_DATA_W-1:0] wdata_i     = '0;
  logic                  wr_i        = 1'b0;
  logic                  rd_i        = 1'b0;
  logic [GIO_NPTS-1:0]   servo_out_i = '0;
  logic [GIO_NPTS-1:0]   servo_oe_i  = '0;
  logic [GIO_NPTS-1:0]   ext_r       = '0;
  logic [GIO_DATA_W-1:0] rdata_o;
  logic [GIO_NPTS-1:0]   pad_in_i, pad_out_o, pad_oe_o, servo_in_o;
  logic [GIO_NBUF-1:0]   buf_dir_o;
  logic [55:0]           sh [4];
  logic [31:0]           v;
  logic [31:0]           rv;
  int seed = 32'h0588689F;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int k, g;
  localparam int POS[4] = '{0, 24, 32, 48};
  localparam int WID[4] = '{24, 8, 16, 8};
  localparam logic [7:0] BASE[4] = '{8'h00, 8'h1C, 8'h2C, 8'h3C};
  localparam logic [55:0] FIX  = 56'hFF0000FF000000;
  localparam logic [55:0] BOUT = 56'hFFFF00FF000000;
  always #2 ref_clk_i = ~ref_clk_i;
  gio_port uut (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o, .buf_dir_o, .servo_out_i,
    .servo_oe_i, .servo_in_o);
  gio_line_model u_line (.ref_clk_i, .pad_out_i(pad_out_o),
    .pad_oe_i(pad_oe_o), .buf_dir_i(buf_dir_o), .ext_i(ext_r),
    .pad_in_o(pad_in_i));
  // =====
  // Expectations
  function automatic logic [55:0] gmask(int g);
    return ((56'h1 << WID[g]) - 56'h1) << POS[g];
  endfunction
  function automatic logic [55:0] x_oe();
    return FIX | (~FIX & ((sh[0] & sh[1]) | (~sh[0] & servo_oe_i)));
  endfunction
  function automatic logic [55:0] x_out();
    return ((FIX | sh[0]) & (sh[3] ^ sh[2])) | (~FIX & ~sh[0] & servo_out_i);
  endfunction
  // =====
  // Bus and compare tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [55:0] got, input logic [55:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input int k, input int g, input logic [31:0] d);
    wr(BASE[k] + 8'(4 * g), d);
    sh[k] = (sh[k] & ~gmask(g)) | ((56'(d) << POS[g]) & gmask(g));
  endtask
  task automatic chk_reg(input int k, input int g);
    logic [31:0] d;
    rd(BASE[k] + 8'(4 * g), d);
    chk_word(d, 32'((sh[k] & gmask(g)) >> POS[g]));
  endtask
  task automatic chk_inp(input int g);
    logic [55:0] ok, ln, ac;
    logic [31:0] d;
    ac = ~BOUT | x_oe();
    ok = ac & gmask(g);
    ln = (BOUT & x_out()) | (~BOUT & ext_r);
    rd(GIO_OFS_LOW_INP + 8'(4 * g), d);
    chk_word(d & 32'(ok >> POS[g]), 32'(((ln ^ sh[2]) & ok) >> POS[g]));
    chk_vec(servo_in_o & ac, ln & ac);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
  // =====
  // Main sequence
  initial begin
    sh[0] = '1;
    for (int i = 1; i < 4; i++) sh[i] = '0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) chk_reg(i / 4, i % 4);
    rd(8'h5C, v);
    chk_word(v, 32'h0);
    rd(8'hFC, v);
    chk_word(v, 32'h0);
    chk_vec(pad_oe_o, x_oe());
    chk_vec(pad_out_o, x_out());
    repeat (6) begin
      v = $random(seed);
      wr(GIO_OFS_ID_CTRL0, v);
      wr(GIO_OFS_ID_VAL0, v >> 8);
      wr(GIO_OFS_ID_VAL1, v >> 16);
      rd(GIO_OFS_ID_CTRL0, rv);
      chk_word(rv, {24'h0, v[7], 7'h00});
      chk_vec(56'(buf_dir_o), 56'({v[17:16], v[11:8], v[7]}));
    end
    wr(GIO_OFS_ID_CTRL0, 32'h0);
    wr(GIO_OFS_ID_VAL0, 32'h4);
    wr(GIO_OFS_ID_VAL1, 32'h3);
    cfg(1, 2, 32'hFF00);
    cfg(2, 2, 32'h0000);
    cfg(0, 0, 32'h00F0F0);
    wr(GIO_OFS_LOW_INP, 32'hFFFFFF);
    repeat (40) begin
      k = $random(seed) & 3;
      g = $random(seed) & 3;
      v = $random(seed);
      if (k == 1) v = {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}};
      cfg(k, g, v);
      servo_oe_i  <= 56'({$random(seed), $random(seed)});
      servo_out_i <= 56'({$random(seed), $random(seed)});
      ext_r       <= 56'({$random(seed), $random(seed)});
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk_vec(pad_oe_o, x_oe());
      chk_vec(pad_out_o, x_out());
      chk_reg(k, g);
      chk_inp(g);
    end
    // Mid-run reset: everything back to defaults, buffers to input
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    sh[0] = '1;
    for (int i = 1; i < 4; i++) sh[i] = '0;
    chk_vec(56'(buf_dir_o), 56'h0);
    for (int i = 0; i < 16; i++) chk_reg(i / 4, i % 4);
    chk_vec(pad_oe_o, x_oe());
    chk_vec(pad_out_o, x_out());
    final_report();
  end
endmodule // tb
